// ---- dv/sec_event_capture_monitor.sv ----
// Checker for the event capture bank, watching its APB ports.
// Assumes clk_en stays high while a transfer is in progress.
`timescale 1ns/1ps
`default_nettype none
module sec_event_capture_monitor
    import sec_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              clk_en,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire rd_ok = pready && !pwrite && !pslverr;

    property p_rdy; psel && !penable && clk_en |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("ready outside access phase");
    property p_hi; rd_ok |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unm; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("refused read returns data");
    property p_rx; rd_ok && paddr == {XCVR_ST_IDX, 2'b00} |-> (prdata[7:0] & ~XCVR_MASK) == 8'h0;
    endproperty
    a_rx: assert property (p_rx) else $error("transceiver status reserved bit set");
    property p_rt; rd_ok && paddr == {TRIG_ST_IDX, 2'b00} |-> (prdata[7:0] & ~TRIG_MASK) == 8'h0;
    endproperty
    a_rt: assert property (p_rt) else $error("trigger status reserved bit set");
    property p_rs; rd_ok && paddr == {SYS_EN_IDX, 2'b00} |-> (prdata[7:0] & ~SYS_MASK) == 8'h0;
    endproperty
    a_rs: assert property (p_rs) else $error("system enable reserved bit set");
    property p_ru; rd_ok && paddr == {SUP_EN_IDX, 2'b00} |-> (prdata[7:0] & ~SUP_MASK) == 8'h0;
    endproperty
    a_ru: assert property (p_ru) else $error("supply enable reserved bit set");
endmodule // sec_event_capture_monitor

bind sec_event_capture sec_event_capture_monitor u_mon (.clk(clk), .reset(reset),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ---- dv/sec_host_model.sv ----
// Host model: an APB master issuing one transfer at a time.
// Assumes the bank answers with pready; the bench timeout bounds any wait.
`timescale 1ns/1ps
`default_nettype none
module sec_host_model
    import sec_pkg::*;
(
    // Clock and answer
    input  wire logic              clk,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    // Request
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [31:0]            pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Request is held until pready is seen at a rising edge.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // sec_host_model
`default_nettype wire

// ---- dv/tb_sec_event_capture.sv ----
// Self-checking bench for the event capture bank.
// Assumes a short silence timeout through the SILENCE_CYCLES parameter.
`timescale 1ns/1ps
`default_nettype none
module tb_sec_event_capture
    import sec_pkg::*;
;
    localparam int SIL = 20;
    localparam logic [7:0] REGS [10] = '{SYS_EN_IDX, SUP_EN_IDX, XCVR_EN_IDX, TRIG_EN_IDX,
        SYS_ST_IDX, SUP_ST_IDX, XCVR_ST_IDX, TRIG_ST_IDX, IRQ_MASK_IDX, IRQ_STAT_IDX};
    localparam logic [7:0] MSK [4] = '{SYS_MASK, SUP_MASK, XCVR_MASK, TRIG_MASK};
    logic              clk, reset, clk_en, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, seed;
    sec_cond_t         cond;
    int                mismatches, n_tests, cyc;

    sec_event_capture #(.SILENCE_CYCLES(SIL)) uut (.clk(clk), .reset(reset), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond), .irq(irq));
    sec_host_model host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            wrap_up();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] exp_en(input int i, input logic [31:0] d);
        return d & {24'h0, MSK[i]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.xfer(1'b1, idx, d, rd, err);
    endtask
    task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] exp);
        host.xfer(1'b0, idx, 32'h0, rd, err);
        check(name, rd, exp);
    endtask
    // Bits 11..0: overtemp serial sec_over sec_under pri_under pri_active
    // off_fail bus_wake offline activity trigger_pin sleep.
    task automatic drive(input logic [11:0] v, input int n);
        cond <= sec_cond_t'(v);
        repeat (n) @(posedge clk);
        cond <= '0;
        repeat (SIL + 10) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        cond = '0;
        clk_en = 1'b1;
        reset = 1'b1;
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        seed = 32'h939a;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) rdc("reset value", REGS[i], 32'h0);
        $display("test reset done");
        wr(TRIG_EN_IDX, 32'hff);
        rdc("trig_en", TRIG_EN_IDX, 32'h03);
        drive(12'h002, 3);
        rdc("trig_st", TRIG_ST_IDX, 32'h03);
        wr(TRIG_ST_IDX, 32'h02);
        rdc("trig_clr", TRIG_ST_IDX, 32'h01);
        wr(TRIG_ST_IDX, 32'h01);
        wr(TRIG_EN_IDX, 32'h0);
        drive(12'h002, 3);
        rdc("trig_off", TRIG_ST_IDX, 32'h0);
        wr(TRIG_EN_IDX, 32'h03);
        clk_en <= 1'b0;
        drive(12'h002, 3);
        clk_en <= 1'b1;
        rdc("trig_frozen", TRIG_ST_IDX, 32'h0);
        wr(TRIG_EN_IDX, 32'h0);
        $display("test trigger done");
        wr(XCVR_EN_IDX, 32'hff);
        rdc("xcvr_en", XCVR_EN_IDX, 32'h13);
        drive(12'h031, 3);
        rdc("xcvr_sleep", XCVR_ST_IDX, 32'h0);
        drive(12'h03c, 1);
        rdc("xcvr_st", XCVR_ST_IDX, 32'h13);
        wr(IRQ_MASK_IDX, 32'h04);
        repeat (2) @(posedge clk);
        check("irq on", {31'h0, irq}, 32'h1);
        wr(IRQ_MASK_IDX, 32'h0);
        repeat (2) @(posedge clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(IRQ_MASK_IDX, 32'h04);
        wr(XCVR_ST_IDX, 32'hff);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rdc("xcvr_clr", XCVR_ST_IDX, 32'h0);
        $display("test transceiver done");
        wr(SYS_EN_IDX, 32'hff);
        wr(SUP_EN_IDX, 32'h01);
        drive(12'hc81, 2);
        rdc("sys_sleep", SYS_ST_IDX, 32'h0);
        rdc("sup_off", SUP_ST_IDX, 32'h0);
        drive(12'hec0, 2);
        rdc("sys_st", SYS_ST_IDX, 32'h06);
        rdc("sup_st", SUP_ST_IDX, 32'h01);
        $display("test system done");
        host.xfer(1'b0, 8'h05, 32'h0, rd, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test unmapped done");
        repeat (8) begin
            seed = xs(seed);
            wr(REGS[seed[1:0]], seed);
            rdc("rand_en", REGS[seed[1:0]], exp_en(seed[1:0], seed));
        end
        $display("test random done");
        wrap_up();
    end
endmodule // tb_sec_event_capture
`default_nettype wire

// ---- hdl/sec_event_capture.sv ----
// Event capture register bank: sticky event flags gated by capture enables, APB slave.
// Assumes condition inputs synchronous to clk and an APB master per the APB protocol.
`timescale 1ns/1ps
`default_nettype none

module sec_event_capture
    import sec_pkg::*;
#(
    parameter int SILENCE_CYCLES = SILENCE_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Event conditions
    input  wire sec_cond_t          cond,
    // Interrupt
    output logic                    irq
);

    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    // The quiet-cycle counter is 32 bits, so any positive int fits in it.
    initial begin
        if (SILENCE_CYCLES < 1) begin
            $error("SILENCE_CYCLES must be at least one");
        end
        if (ADDR_W != 10) begin
            $error("ADDR_W must be ten so that a register index is one byte");
        end
        if (SYS_MASK[OTW_BIT] != 1'b1 || SYS_MASK[SERIAL_FAIL_FLAG_BIT] != 1'b1) begin
            $error("system mask does not cover its enable fields");
        end
        if (SUP_MASK[SEC_OVER_BIT] != 1'b1 || SUP_MASK[SEC_UNDER_BIT] != 1'b1) begin
            $error("supply mask does not cover its secondary fields");
        end
        if (SUP_MASK[PRI_UNDER_BIT] != 1'b1) begin
            $error("supply mask does not cover its primary field");
        end
        if (XCVR_MASK[SILENCE_BIT] != 1'b1 || XCVR_MASK[CANFAIL_BIT] != 1'b1) begin
            $error("transceiver mask does not cover its enable fields");
        end
        if (XCVR_MASK[WAKE_BIT] != 1'b1) begin
            $error("transceiver mask does not cover its wake-up field");
        end
        if (TRIG_MASK[RISE_BIT] != 1'b1 || TRIG_MASK[FALL_BIT] != 1'b1) begin
            $error("trigger mask does not cover its edge fields");
        end
        if (IRQ_SYS > 3 || IRQ_SUP > 3 || IRQ_XCVR > 3 || IRQ_TRIG > 3) begin
            $error("interrupt group positions must lie in the four-bit mask");
        end
    end

    // -------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------
    sec_bank_t  en_q;
    sec_bank_t  st_q;
    sec_bank_t  ev;
    logic [3:0] irq_mask_q;
    logic       trig_q;
    logic       bus_seen_q;
    logic       silence_done_q;
    logic [31:0] silence_cnt_q;

    // -------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic [7:0] idx;
    logic       mapped;
    logic [7:0] wbyte;

    assign acc   = psel && penable && clk_en;
    assign wr    = acc && pwrite;
    assign idx   = paddr[ADDR_W-1:2];
    assign wbyte = pwdata[7:0];

    // -------------------------------------------------------------------
    // Per-register clear strobes
    // -------------------------------------------------------------------
    // Each strobe already holds clk_en through wr, so a frozen bank ignores the bus.
    logic       clr_sys;
    logic       clr_sup;
    logic       clr_xcvr;
    logic       clr_trig;

    assign clr_sys  = wr && mapped && (idx == SYS_ST_IDX);
    assign clr_sup  = wr && mapped && (idx == SUP_ST_IDX);
    assign clr_xcvr = wr && mapped && (idx == XCVR_ST_IDX);
    assign clr_trig = wr && mapped && (idx == TRIG_ST_IDX);

    always_comb begin
        unique case (idx)
            SYS_EN_IDX, SUP_EN_IDX, XCVR_EN_IDX, TRIG_EN_IDX,
            SYS_ST_IDX, SUP_ST_IDX, XCVR_ST_IDX, TRIG_ST_IDX,
            IRQ_MASK_IDX, IRQ_STAT_IDX: mapped = (paddr[1:0] == 2'b00);
            default:                    mapped = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------
    // Enable registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_q       <= '{EN_RESET, EN_RESET, EN_RESET, EN_RESET};
            irq_mask_q <= IRQ_RESET;
        end else if (wr && mapped) begin
            if (idx == SYS_EN_IDX) en_q.sys <= wbyte & SYS_MASK;
            if (idx == SUP_EN_IDX) en_q.sup <= wbyte & SUP_MASK;
            if (idx == XCVR_EN_IDX) en_q.xcvr <= wbyte & XCVR_MASK;
            if (idx == TRIG_EN_IDX) en_q.trig <= wbyte & TRIG_MASK;
            if (idx == IRQ_MASK_IDX) irq_mask_q <= wbyte[3:0];
        end
    end

    // -------------------------------------------------------------------
    // Trigger pin edge history
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trig_q <= 1'b0;
        end else if (clk_en) begin
            trig_q <= cond.trigger_pin;
        end
    end

    // -------------------------------------------------------------------
    // Bus silence timer
    // -------------------------------------------------------------------
    // Armed by activity; counts quiet cycles and fires once per quiet period.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_seen_q     <= 1'b0;
            silence_cnt_q  <= '0;
            silence_done_q <= 1'b0;
        end else if (clk_en) begin
            silence_done_q <= 1'b0;
            if (cond.bus_activity) begin
                bus_seen_q    <= 1'b1;
                silence_cnt_q <= '0;
            end else if (bus_seen_q) begin
                if (silence_cnt_q == 32'(SILENCE_CYCLES - 1)) begin
                    silence_done_q <= 1'b1;
                    bus_seen_q     <= 1'b0;
                    silence_cnt_q  <= '0;
                end else begin
                    silence_cnt_q <= silence_cnt_q + 32'd1;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Event detection
    // -------------------------------------------------------------------
    // -------------------------------------------------------------------
    // Trigger pin edges
    // -------------------------------------------------------------------
    // History resets low, so a pin already high at release counts as rising.
    logic       trig_rise;
    logic       trig_fall;

    assign trig_rise = cond.trigger_pin && !trig_q;
    assign trig_fall = !cond.trigger_pin && trig_q;

    always_comb begin
        ev = '{8'h00, 8'h00, 8'h00, 8'h00};
        ev.sys[OTW_BIT]  = cond.overtemp && !cond.sleep_mode;
        ev.sys[SERIAL_FAIL_FLAG_BIT] = cond.serial_fail && !cond.sleep_mode;
        ev.sup[SEC_OVER_BIT]  = cond.sec_over;
        ev.sup[SEC_UNDER_BIT] = cond.sec_under;
        ev.sup[PRI_UNDER_BIT] = cond.pri_under && cond.pri_active;
        ev.xcvr[SILENCE_BIT]  = silence_done_q;
        ev.xcvr[CANFAIL_BIT]  = cond.xcvr_off_fail && !cond.sleep_mode;
        ev.xcvr[WAKE_BIT]     = cond.bus_wake && cond.xcvr_offline;
        ev.trig[RISE_BIT]     = trig_rise;
        ev.trig[FALL_BIT]     = trig_fall;
        ev = ev & en_q;
    end

    // -------------------------------------------------------------------
    // Sticky status flags
    // -------------------------------------------------------------------
    function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                          input logic clr_hit, input logic [7:0] clr,
                                          input logic [7:0] msk);
        logic [7:0] c;
        c = clr_hit ? (clr & msk) : 8'h00;
        return ((cur & ~c) | set) & msk;
    endfunction

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '{ST_RESET, ST_RESET, ST_RESET, ST_RESET};
        end else if (clk_en) begin
            // Set wins over a simultaneous clear.
            st_q.sys  <= sticky(st_q.sys,  ev.sys,  clr_sys,  wbyte, SYS_MASK);
            st_q.sup  <= sticky(st_q.sup,  ev.sup,  clr_sup,  wbyte, SUP_MASK);
            st_q.xcvr <= sticky(st_q.xcvr, ev.xcvr, clr_xcvr, wbyte, XCVR_MASK);
            st_q.trig <= sticky(st_q.trig, ev.trig, clr_trig, wbyte, TRIG_MASK);
        end
    end

    // -------------------------------------------------------------------
    // Interrupt
    // -------------------------------------------------------------------
    logic [3:0] pend;

    assign pend[IRQ_SYS]  = |st_q.sys;
    assign pend[IRQ_SUP]  = |st_q.sup;
    assign pend[IRQ_XCVR] = |st_q.xcvr;
    assign pend[IRQ_TRIG] = |st_q.trig;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(pend & irq_mask_q);
        end
    end

    // -------------------------------------------------------------------
    // Read data and response
    // -------------------------------------------------------------------
    logic [7:0] rbyte;

    always_comb begin
        unique case (idx)
            SYS_EN_IDX:   rbyte = en_q.sys;
            SUP_EN_IDX:   rbyte = en_q.sup;
            XCVR_EN_IDX:  rbyte = en_q.xcvr;
            TRIG_EN_IDX:  rbyte = en_q.trig;
            SYS_ST_IDX:   rbyte = st_q.sys;
            SUP_ST_IDX:   rbyte = st_q.sup;
            XCVR_ST_IDX:  rbyte = st_q.xcvr;
            TRIG_ST_IDX:  rbyte = st_q.trig;
            IRQ_MASK_IDX: rbyte = {4'h0, irq_mask_q};
            IRQ_STAT_IDX: rbyte = {4'h0, pend};
            default:      rbyte = 8'h00;
        endcase
    end

    // Zero-wait-state slave: pready, pslverr and prdata are registered from the setup cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite && mapped) ? {24'h00_0000, rbyte}
                                                               : 32'h0000_0000;
        end
    end

endmodule // sec_event_capture

`default_nettype wire

// ---- hdl/sec_pkg.sv ----
// Package for the event capture register bank: offsets, field positions, reset values, types.
// Assumes a 32-bit APB register bus with byte addresses made from register indices.
package sec_pkg;

    // -------------------------------------------------------------------
    // Register indices and byte addresses
    // -------------------------------------------------------------------
    localparam logic [7:0]  SYS_EN_IDX       = 8'h04;
    localparam logic [7:0]  SUP_EN_IDX       = 8'h1c;
    localparam logic [7:0]  XCVR_EN_IDX      = 8'h23;
    localparam logic [7:0]  TRIG_EN_IDX      = 8'h4c;
    localparam logic [7:0]  SYS_ST_IDX       = 8'h61;
    localparam logic [7:0]  SUP_ST_IDX       = 8'h62;
    localparam logic [7:0]  XCVR_ST_IDX      = 8'h63;
    localparam logic [7:0]  TRIG_ST_IDX      = 8'h64;
    localparam logic [7:0]  IRQ_MASK_IDX     = 8'h80;
    localparam logic [7:0]  IRQ_STAT_IDX     = 8'h81;
    localparam int          ADDR_W           = 10;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int          OTW_BIT          = 2;
    localparam int          SERIAL_FAIL_FLAG_BIT         = 1;
    localparam int          SEC_OVER_BIT     = 2;
    localparam int          SEC_UNDER_BIT    = 1;
    localparam int          PRI_UNDER_BIT    = 0;
    localparam int          SILENCE_BIT      = 4;
    localparam int          CANFAIL_BIT      = 1;
    localparam int          WAKE_BIT         = 0;
    localparam int          RISE_BIT         = 1;
    localparam int          FALL_BIT         = 0;

    // Writable bit masks; all other bits are reserved and read as zero.
    localparam logic [7:0]  SYS_MASK         = 8'h06;
    localparam logic [7:0]  SUP_MASK         = 8'h07;
    localparam logic [7:0]  XCVR_MASK        = 8'h13;
    localparam logic [7:0]  TRIG_MASK        = 8'h03;
    localparam logic [7:0]  EN_RESET         = 8'h00;
    localparam logic [7:0]  ST_RESET         = 8'h00;

    // Interrupt summary bit positions, one per status register.
    localparam int          IRQ_SYS          = 0;
    localparam int          IRQ_SUP          = 1;
    localparam int          IRQ_XCVR         = 2;
    localparam int          IRQ_TRIG         = 3;
    localparam logic [3:0]  IRQ_RESET        = 4'h0;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int          CLK_MHZ          = 250;
    localparam int          SILENCE_US       = 1000;
    localparam int          SILENCE_CYC      = SILENCE_US * CLK_MHZ;

    // -------------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic overtemp;
        logic serial_fail;
        logic sec_over;
        logic sec_under;
        logic pri_under;
        logic pri_active;
        logic xcvr_off_fail;
        logic bus_wake;
        logic xcvr_offline;
        logic bus_activity;
        logic trigger_pin;
        logic sleep_mode;
    } sec_cond_t;

    typedef struct packed {
        logic [7:0] sys;
        logic [7:0] sup;
        logic [7:0] xcvr;
        logic [7:0] trig;
    } sec_bank_t;

endpackage
